/* File: hdl/gpsm_sync.sv */
`timescale 1ns/100ps
module gpsm_sync
  #(parameter int W = 1)
  (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
  );
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta <= '0;
      q_out <= '0;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

/* File: hdl/gpsm_top.sv */
`timescale 1ns/100ps
module gpsm_top
  import gpsm_pkg::*;
  #(parameter logic [6:0] SLAVE_ADDR = 7'h48)
  (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic scl_clk_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic general_pin_one_in,
  output logic general_pin_one_out,
  output logic general_pin_one_oe_out,
  input wire logic general_pin_two_in,
  output logic general_pin_two_out,
  output logic general_pin_two_oe_out,
  input wire logic general_pin_three_in,
  output logic general_pin_three_out,
  output logic general_pin_three_oe_out,
  input wire logic power_feedback_in,
  input wire logic gate_on_in,
  input wire logic [FAULT_W-1:0] fault_in,
  output logic power_bad_out,
  output logic bus_busy_out
  );

  // bus clock domain: bits taken on rising edge, engine on falling edge
  gpsm_state_t state;
  gpsm_state_t next_state;
  logic sda_pos;
  logic [2:0] bit_cnt;
  logic [2:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic next_oe;
  logic is_read;
  logic next_read;
  logic is_ara;
  logic next_ara;
  logic wrote;
  logic [2:0] ptr;
  logic alert_rel_tgl;
  logic start_seen;
  logic start_tgl;
  logic start_took;
  logic own_hit;
  logic ara_hit;
  logic addr_hit;
  logic wr_en;
  logic [7:0] read_val;
  logic [7:0] ctrl_reg;
  logic [7:0] alert_reg;
  logic [1:0] pin23_out;
  logic [2:0] pincfg_reg;
  logic [10:0] stat_s;
  logic [10:0] stat_src;

  always_ff @(posedge scl_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sda_pos <= 1'b1;
    else
      sda_pos <= sda_in;
  end

  // data fell while the clock was high: seen on the next falling edge;
  // a start right after a stop has no bus clock edge in between, so the
  // data line's own falling edge records it, and the bus hold time covers
  // the step into the falling-edge engine
  always_ff @(negedge sda_in or negedge resetn_in)
  begin
    if (!resetn_in)
      start_tgl <= 1'b0;
    else if (scl_clk_in)
      start_tgl <= !start_tgl;
  end

  always_ff @(negedge scl_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      start_took <= 1'b0;
    else
      start_took <= start_tgl;
  end

  assign start_seen = start_tgl ^ start_took;
  assign own_hit = (shift[6:0] == SLAVE_ADDR);
  assign ara_hit = (shift[6:0] == ARA_ADDR) && sda_pos && stat_s[6];
  assign addr_hit = own_hit || ara_hit
    || ((shift[6:0] == MASS_ADDR) && !sda_pos && ctrl_reg[MASS_EN_BIT]);
  assign wr_en = (state == ST_WDATA_ACK) && !wrote && !start_seen;

  always_comb
  begin
    read_val = 8'h00;
    case (ptr)
      REG_CTRL: read_val = ctrl_reg;
      REG_ALERT: read_val = alert_reg;
      REG_STATUS: read_val = {1'b0, stat_s[10], stat_s[9], 1'b0,
        stat_s[7], stat_s[8], 2'h0};
      REG_FAULT: read_val = {pin23_out, stat_s[FAULT_W-1:0]};
      REG_PINCFG: read_val = {5'h00, pincfg_reg};
      default: read_val = 8'h00;
    endcase
  end

  // the serial slave state machine
  always_comb
  begin
    next_state = state;
    next_cnt = bit_cnt + 3'h1;
    next_shift = {shift[6:0], sda_pos};
    next_tx = tx;
    next_oe = 1'b0;
    next_read = is_read;
    next_ara = is_ara;
    if (start_seen)
    begin
      next_state = ST_ADDR;
      next_cnt = 3'h0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          next_cnt = 3'h0;
        ST_ADDR:
          if (bit_cnt == 3'h7)
          begin
            next_read = sda_pos;
            next_ara = ara_hit && !own_hit;
            next_state = addr_hit ? ST_ADDR_ACK : ST_IDLE;
            next_oe = addr_hit;
          end
        ST_ADDR_ACK:
        begin
          next_cnt = 3'h0;
          next_shift = shift;
          if (is_read)
          begin
            next_tx = is_ara ? {SLAVE_ADDR, 1'b0} : read_val;
            next_oe = is_ara ? !SLAVE_ADDR[6] : !read_val[7];
            next_state = ST_RDATA;
          end
          else
            next_state = ST_CMD;
        end
        ST_CMD:
          if (bit_cnt == 3'h7)
          begin
            next_state = ST_CMD_ACK;
            next_oe = 1'b1;
          end
        ST_CMD_ACK:
        begin
          next_cnt = 3'h0;
          next_shift = shift;
          next_state = ST_WDATA;
        end
        ST_WDATA:
          if (bit_cnt == 3'h7)
          begin
            next_state = ST_WDATA_ACK;
            next_oe = 1'b1;
          end
        ST_WDATA_ACK:
        begin
          // further bytes are acknowledged and dropped
          next_cnt = 3'h0;
          next_shift = shift;
          next_state = ST_WDATA;
        end
        ST_RDATA:
          if (bit_cnt == 3'h7)
            next_state = ST_RDATA_ACK;
          else
          begin
            next_tx = {tx[6:0], 1'b0};
            next_oe = !tx[6];
          end
        ST_RDATA_ACK:
        begin
          next_cnt = 3'h0;
          if (!sda_pos && !is_ara)
          begin
            next_tx = read_val;
            next_oe = !read_val[7];
            next_state = ST_RDATA;
          end
          else
            next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(negedge scl_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      sda_oe_out <= 1'b0;
      is_read <= 1'b0;
      is_ara <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_cnt;
      shift <= next_shift;
      tx <= next_tx;
      sda_oe_out <= next_oe;
      is_read <= next_read;
      is_ara <= next_ara;
    end
  end

  // pointer load and the one-byte write marker
  always_ff @(negedge scl_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ptr <= 3'h0;
      wrote <= 1'b0;
    end
    else
    begin
      if (state == ST_CMD_ACK && !start_seen)
      begin
        ptr <= shift[2:0];
        wrote <= 1'b0;
      end
      else if (wr_en)
        wrote <= 1'b1;
    end
  end

  // being addressed or answering the alert address frees pin two
  always_ff @(negedge scl_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      alert_rel_tgl <= 1'b0;
    else if (state == ST_ADDR && bit_cnt == 3'h7 && !start_seen
      && (own_hit || ara_hit))
      alert_rel_tgl <= !alert_rel_tgl;
  end

  always_ff @(negedge scl_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ctrl_reg <= CTRL_RST;
      alert_reg <= ALERT_RST;
      pin23_out <= PINOUT_RST;
      pincfg_reg <= PINCFG_RST;
    end
    else if (wr_en)
    begin
      case (ptr)
        REG_CTRL: ctrl_reg <= shift;
        REG_ALERT: alert_reg <= shift;
        REG_FAULT: pin23_out <= shift[7:6];
        REG_PINCFG: pincfg_reg <= shift[2:0];
        default: ;
      endcase
    end
  end

  // the idle line level never comes from this end
  always_ff @(negedge scl_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // status levels cross into the bus domain; they are only as fresh as the
  // last two bus clock edges, acceptable for slow pin levels
  gpsm_sync #(.W(11)) u_stat_sync (
    .clk_in(scl_clk_in),
    .resetn_in(resetn_in),
    .d_in(stat_src),
    .q_out(stat_s)
  );

  // system clock domain
  localparam logic [14:0] CFG_RST = {CTRL_RST[7:6], ALERT_RST, PINOUT_RST,
    PINCFG_RST};
  logic [14:0] cfg_s;
  logic [14:0] cfg_d;
  logic [14:0] cfg_q;
  logic [14:0] cfg;
  logic [7:0] pins_s;
  logic [1:0] p1_mode;
  logic [1:0] p2_mode;
  logic [5:0] alert_en;
  logic p1_out_bit;
  logic p2_out_bit;
  logic p3_out_bit;
  logic p3_input;
  logic fb_s;
  logic gate_s;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic rel_d;
  logic rel_evt;
  logic bus_start;
  logic bus_stop;
  logic [FAULT_W-1:0] fault_r;
  logic [FAULT_W-1:0] masked_d;
  logic [FAULT_W-1:0] masked;
  logic new_fault;
  logic alert_act;
  logic alert_resp;
  logic [6:0] pb_cnt;
  logic pbad;

  // the sync stages reset to zero, so the word crosses as its difference
  // from the reset value: pins keep their reset state while it settles
  gpsm_sync #(.W(15)) u_cfg_sync (
    .clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .d_in({ctrl_reg[7:6], alert_reg, pin23_out, pincfg_reg} ^ CFG_RST),
    .q_out(cfg_s)
  );

  gpsm_sync #(.W(8)) u_pin_sync (
    .clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .d_in({general_pin_one_in, general_pin_two_in, general_pin_three_in,
      power_feedback_in, gate_on_in, scl_clk_in, sda_in, alert_rel_tgl}),
    .q_out(pins_s)
  );

  // a word is taken only after it held for two edges, so a half-updated
  // word from the crossing never reaches the pins
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cfg_d <= 15'h0000;
      cfg_q <= 15'h0000;
    end
    else
    begin
      cfg_d <= cfg_s;
      if (cfg_s == cfg_d)
        cfg_q <= cfg_s;
    end
  end

  assign cfg = cfg_q ^ CFG_RST;
  assign p1_mode = cfg[14:13];
  assign p1_out_bit = cfg[5 + P1_OUT_BIT];
  assign alert_en = cfg[10:5];
  assign p3_out_bit = cfg[4];
  assign p2_out_bit = cfg[3];
  assign p3_input = cfg[2];
  assign p2_mode = cfg[1:0];
  assign fb_s = pins_s[4];
  assign gate_s = pins_s[3];
  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign rel_evt = pins_s[0] ^ rel_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
  assign masked = fault_r & alert_en;
  assign new_fault = |(masked & ~masked_d);
  assign stat_src = {pins_s[7:5], pbad, alert_resp, fault_r};

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rel_d <= 1'b0;
      fault_r <= '0;
      masked_d <= '0;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      rel_d <= pins_s[0];
      fault_r <= fault_in;
      masked_d <= masked;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      bus_busy_out <= 1'b0;
    else if (bus_start)
      bus_busy_out <= 1'b1;
    else if (bus_stop)
      bus_busy_out <= 1'b0;
  end

  // a fresh enabled fault arms the alert; set wins over release
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      alert_act <= 1'b0;
      alert_resp <= 1'b0;
    end
    else
    begin
      if (new_fault)
        alert_act <= 1'b1;
      else if (rel_evt)
        alert_act <= 1'b0;
      alert_resp <= alert_act && (p2_mode == P2_ALERT);
    end
  end

  // gate-off blocks power-bad so start-up ramps do not trip it
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pb_cnt <= 7'h00;
      pbad <= 1'b0;
    end
    else if (!fb_s && gate_s)
    begin
      if (pb_cnt == PB_CYC)
        pbad <= 1'b1;
      else
        pb_cnt <= pb_cnt + 7'h01;
    end
    else
    begin
      pb_cnt <= 7'h00;
      if (fb_s)
        pbad <= 1'b0;
    end
  end

  // open-drain pins: only the enables move
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      general_pin_one_oe_out <= 1'b0;
      general_pin_two_oe_out <= 1'b0;
      general_pin_three_oe_out <= 1'b0;
      general_pin_one_out <= 1'b0;
      general_pin_two_out <= 1'b0;
      general_pin_three_out <= 1'b0;
      power_bad_out <= 1'b0;
    end
    else
    begin
      unique case (p1_mode)
        P1_OUT: general_pin_one_oe_out <= !p1_out_bit;
        P1_PG_REL: general_pin_one_oe_out <= pbad;
        P1_PG_LOW: general_pin_one_oe_out <= !pbad;
        P1_IN: general_pin_one_oe_out <= 1'b0;
      endcase
      if (p2_mode == P2_OUT)
        general_pin_two_oe_out <= p2_out_bit;
      else if (p2_mode == P2_ALERT)
        general_pin_two_oe_out <= p2_out_bit || alert_act;
      else
        general_pin_two_oe_out <= 1'b0;
      general_pin_three_oe_out <= p3_out_bit && !p3_input;
      general_pin_one_out <= 1'b0;
      general_pin_two_out <= 1'b0;
      general_pin_three_out <= 1'b0;
      power_bad_out <= pbad;
    end
  end

  sequence s_cmd_done;
    state == ST_CMD_ACK && !start_seen;
  endsequence

  sequence s_ara_refused;
    state == ST_ADDR && bit_cnt == 3'h7 && !start_seen
      && shift[6:0] == ARA_ADDR && sda_pos && !stat_s[6];
  endsequence

  a_ptr_load_cmd: assert property (@(negedge scl_clk_in)
    disable iff (!resetn_in) s_cmd_done |=> ptr == $past(shift[2:0]))
    else $error("pointer not loaded from command byte");

  a_ara_no_ack: assert property (@(negedge scl_clk_in)
    disable iff (!resetn_in) s_ara_refused and !own_hit |=> !sda_oe_out)
    else $error("alert address acknowledged without alert");

  a_idle_released: assert property (@(negedge scl_clk_in)
    disable iff (!resetn_in) state == ST_IDLE |-> !sda_oe_out)
    else $error("data line pulled while idle");

  a_word_write_drop: assert property (@(negedge scl_clk_in)
    disable iff (!resetn_in) state == ST_WDATA_ACK && wrote |=>
    $stable(ctrl_reg) && $stable(alert_reg) && $stable(pin23_out))
    else $error("second data byte changed a register");

  a_word_read_repeat: assert property (@(negedge scl_clk_in)
    disable iff (!resetn_in)
    state == ST_RDATA_ACK && !sda_pos && !is_ara && !start_seen
    |=> tx == $past(read_val) ##1 state == ST_RDATA)
    else $error("second read byte differs from first");

  a_pin1_out_mode: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) p1_mode == P1_OUT |=>
    general_pin_one_oe_out == !$past(p1_out_bit))
    else $error("pin one output level wrong");

  a_power_bad_filter: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) $rose(pbad) |-> $past(pb_cnt) == PB_CYC
    && !$past(fb_s) && $past(gate_s))
    else $error("power bad set without full filter time");

  a_pg_release: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    p1_mode == P1_PG_REL && pbad |=> general_pin_one_oe_out)
    else $error("power-good pin not pulled on power bad");

  a_alert_pulls: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) p2_mode == P2_ALERT && alert_act
    |=> general_pin_two_oe_out)
    else $error("alert not driven on pin two");

  a_pin3_output: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) !p3_input |=>
    general_pin_three_oe_out == $past(p3_out_bit))
    else $error("pin three output level wrong");

  a_bus_stop_free: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) bus_stop && !bus_start |=> !bus_busy_out)
    else $error("bus still busy after stop");

  a_bus_start_busy: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) bus_start |=> bus_busy_out [*1])
    else $error("start did not mark bus busy");
endmodule

/* File: inc/gpsm_pkg.sv */
// What this block does
// - two function-select bits in the control register pick pin one's function.
// - pin one resets to output mode, level from out bit, reset 1, released.
// - pin one also: release on power good, pull low on power good, input.
// - pin one's sampled level reads back in the status register.
// - pin two can be alert output, general output or general input.
// - pin two's sampled level reads back in the status register.
// - pin three is output or input; out bit resets 1, pulling it low.
// - pin three's sampled level reads back in the status register.
// - serial slave accepting read byte, write byte, read word, write word.
// - second byte of a word read repeats the same register contents.
// - second byte of a word write is acknowledged but changes nothing.
// - master opens with start, data falling while clock high; slave restarts.
// - master closes with stop, data rising while clock high; bus becomes free.
// - with no transfer in progress neither line is pulled low.
// - after the command acknowledge its low three bits load the register pointer.
// - pin two in alert mode pulls low on an enabled fault.
// - power-good pin pulls low once feedback stays low over 2us, gate on.
// - alert response address ignored when pin two is low only by out bit.
package gpsm_pkg;
  // register pointer values
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ALERT = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_FAULT = 3'h3;
  localparam logic [2:0] REG_PINCFG = 3'h7;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] ALERT_RST = 8'h40;
  localparam logic [1:0] PINOUT_RST = 2'h2;
  localparam logic [2:0] PINCFG_RST = 3'h0;
  // field positions
  localparam int MASS_EN_BIT = 4;
  localparam int P1_OUT_BIT = 6;
  localparam int FAULT_W = 6;
  // pin one functions, from the two select bits
  localparam logic [1:0] P1_OUT = 2'h0;
  localparam logic [1:0] P1_PG_REL = 2'h1;
  localparam logic [1:0] P1_PG_LOW = 2'h2;
  localparam logic [1:0] P1_IN = 2'h3;
  // pin two functions
  localparam logic [1:0] P2_OUT = 2'h0;
  localparam logic [1:0] P2_ALERT = 2'h1;
  // bus addresses
  localparam logic [6:0] MASS_ADDR = 7'h5F;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  // power-bad filter
  localparam int SYS_CLK_NS = 25;
  localparam int PB_FILTER_NS = 2000;
  localparam int PB_CYC_I = (PB_FILTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [6:0] PB_CYC = 7'(PB_CYC_I);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } gpsm_state_t;
endpackage

/* File: tb/gpsm_bus_master.sv */
`timescale 1ns/100ps
module gpsm_bus_master
  (
  input wire logic sda_wire_in,
  output logic scl_out,
  output logic sda_low_out
  );
  // both lines rest released between frames, clock stands still there
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // data moves mid-low and is sampled mid-high, never near an edge
  task automatic bit_io(input logic b, output logic r);
    #31.2 sda_low_out = ~b;
    #31.3 scl_out = 1'b1;
    #31.2 r = sda_wire_in;
    #31.3 scl_out = 1'b0;
  endtask
  // serves as repeated start too; leaves the clock low
  task automatic start();
    #31.2 sda_low_out = 1'b0;
    #31.3 scl_out = 1'b1;
    #31.2 sda_low_out = 1'b1;
    #31.3 scl_out = 1'b0;
  endtask
  task automatic stop();
    #31.2 sda_low_out = 1'b1;
    #31.3 scl_out = 1'b1;
    #31.2 sda_low_out = 1'b0;
    #31.3;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

/* File: tb/gpsm_top_tb.sv */
`timescale 1ns/100ps
module gpsm_top_tb;
  import gpsm_pkg::*;
  localparam logic [6:0] SADDR = 7'h48;
  localparam int LIMIT = 30000;
  typedef struct packed {
    logic [1:0] m1; logic pv; logic [1:0] m2; logic p2o;
    logic p3i; logic p3o; logic pb; logic [2:0] oe;
  } gpsm_row_t;
  logic clk, resetn, fb, gate;
  logic [FAULT_W-1:0] fault;
  logic scl, sda_low, sda, sda_o, sda_oe, busy, pbad;
  logic [2:0] pin_o, pin_oe, pin_i;
  int err_total, total_checks, cyc;
  gpsm_row_t rows [7];

  // open drain wires with pull-ups
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
  assign pin_i = (pin_o & pin_oe) | ~pin_oe;

  gpsm_top #(.SLAVE_ADDR(SADDR)) u_dut (
    .sys_clk_in(clk), .resetn_in(resetn), .scl_clk_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .general_pin_one_in(pin_i[0]), .general_pin_one_out(pin_o[0]),
    .general_pin_one_oe_out(pin_oe[0]),
    .general_pin_two_in(pin_i[1]), .general_pin_two_out(pin_o[1]),
    .general_pin_two_oe_out(pin_oe[1]),
    .general_pin_three_in(pin_i[2]), .general_pin_three_out(pin_o[2]),
    .general_pin_three_oe_out(pin_oe[2]),
    .power_feedback_in(fb), .gate_on_in(gate), .fault_in(fault),
    .power_bad_out(pbad), .bus_busy_out(busy));

  gpsm_bus_master u_mst (
    .sda_wire_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic wr(input logic [6:0] a, input logic [2:0] p,
    input logic [7:0] d, input logic word);
    logic [3:0] k;
    k[0] = 1'b1;
    u_mst.start();
    u_mst.tx({a, 1'b0}, k[3]);
    // junk in the upper command bits must not matter
    u_mst.tx({5'h1F, p}, k[2]);
    u_mst.tx(d, k[1]);
    if (word)
      u_mst.tx(8'hC3, k[0]);
    u_mst.stop();
    check("write acks", {4'h0, k}, 8'h0F);
  endtask

  task automatic rd(input logic [2:0] p, input logic word,
    output logic [7:0] d);
    logic [2:0] k;
    logic [7:0] d2;
    u_mst.start();
    u_mst.tx({SADDR, 1'b0}, k[2]);
    u_mst.tx({5'h1F, p}, k[1]);
    u_mst.start();
    u_mst.tx({SADDR, 1'b1}, k[0]);
    u_mst.rx(word, d);
    if (word)
    begin
      u_mst.rx(1'b0, d2);
      check("word repeat", d2, d);
    end
    u_mst.stop();
    check("read acks", {5'h0, k}, 8'h07);
  endtask

  task automatic ara(input logic exp);
    logic k;
    logic [7:0] d;
    u_mst.start();
    u_mst.tx({ARA_ADDR, 1'b1}, k);
    if (k)
      u_mst.rx(1'b0, d);
    u_mst.stop();
    check("ara ack", {7'h0, k}, {7'h0, exp});
    if (k)
      check("ara byte", d, {SADDR, 1'b0});
  endtask

  initial
  begin
    gpsm_row_t r;
    logic [7:0] d;
    logic k;
    resetn = 1'b0;
    fb = 1'b1;
    gate = 1'b0;
    fault = '0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    rows[0] = {2'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h4};
    rows[1] = {2'h0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 3'h3};
    rows[2] = {2'h1, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0};
    rows[3] = {2'h1, 1'b1, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 3'h5};
    rows[4] = {2'h2, 1'b1, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 3'h0};
    rows[5] = {2'h2, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h3};
    rows[6] = {2'h3, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i])
    begin
      r = rows[i];
      @(posedge clk);
      fb <= ~r.pb;
      gate <= 1'b1;
      wr(SADDR, REG_CTRL, {r.m1, 6'h10}, 1'b0);
      wr(SADDR, REG_ALERT, {1'b0, r.pv, 6'h00}, 1'b0);
      wr(SADDR, REG_FAULT, {r.p3o, r.p2o, 6'h00}, 1'b0);
      wr(SADDR, REG_PINCFG, {5'h00, r.p3i, r.m2}, 1'b0);
      repeat (8) @(posedge clk);
      check("pin oe", {5'h0, pin_oe}, {5'h0, r.oe});
      check("pin drive", {4'h0, pin_o, sda_o}, 8'h00);
      check("power bad", {7'h0, pbad}, {7'h0, r.pb});
      rd(REG_STATUS, 1'b0, d);
      check("status", d & 8'h6C, {1'b0, ~r.oe[0], ~r.oe[1], 1'b0,
        r.pb, ~r.oe[2], 2'h0});
      $display("row %0d done", i);
    end
    wr(SADDR, REG_ALERT, 8'h00, 1'b1);
    rd(REG_ALERT, 1'b1, d);
    check("word write", d, 8'h00);
    u_mst.start();
    repeat (6) @(posedge clk);
    check("busy", {7'h0, busy}, 8'h01);
    u_mst.tx({7'h33, 1'b0}, k);
    u_mst.stop();
    repeat (6) @(posedge clk);
    check("bad addr", {5'h0, k, busy, sda_oe}, 8'h00);
    wr(MASS_ADDR, REG_PINCFG, 8'h04, 1'b0);
    rd(REG_PINCFG, 1'b0, d);
    check("mass write", d, 8'h04);
    $display("bus test done");
    @(posedge clk);
    fb <= 1'b1;
    repeat (6) @(posedge clk);
    fb <= 1'b0;
    repeat (60) @(posedge clk);
    fb <= 1'b1;
    repeat (6) @(posedge clk);
    check("short dip", {7'h0, pbad}, 8'h00);
    fb <= 1'b0;
    repeat (95) @(posedge clk);
    check("long dip", {7'h0, pbad}, 8'h01);
    fb <= 1'b1;
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    fb <= 1'b0;
    repeat (120) @(posedge clk);
    check("gate off", {7'h0, pbad}, 8'h00);
    $display("power test done");
    wr(SADDR, REG_PINCFG, 8'h01, 1'b0);
    wr(SADDR, REG_ALERT, 8'h41, 1'b0);
    @(posedge clk);
    fault <= 6'h01;
    repeat (8) @(posedge clk);
    check("alert low", {7'h0, pin_oe[1]}, 8'h01);
    ara(1'b1);
    repeat (8) @(posedge clk);
    check("alert freed", {7'h0, pin_oe[1]}, 8'h00);
    wr(SADDR, REG_FAULT, 8'h40, 1'b0);
    repeat (8) @(posedge clk);
    check("out bit low", {7'h0, pin_oe[1]}, 8'h01);
    ara(1'b0);
    $display("alert test done");
    @(posedge clk);
    fault <= '0;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    check("reset pins", {4'h0, pin_oe, sda_oe}, 8'h08);
    rd(REG_CTRL, 1'b0, d);
    check("ctrl reset", d, CTRL_RST);
    rd(REG_ALERT, 1'b0, d);
    check("alert reset", d, ALERT_RST);
    rd(REG_FAULT, 1'b0, d);
    check("fault reset", d & 8'hC0, 8'h80);
    rd(REG_PINCFG, 1'b0, d);
    check("cfg reset", d & 8'h07, 8'h00);
    $display("reset test done");
    close_out();
  end
endmodule
